// File: rtl/ercf_pkg.sv
// constants for the ecg rate/filter decode and beat detector configuration
// assumes a register port with word addresses, one access per cycle
// Notes on behaviour
// - an unsupported clock/rate/cutoff combination runs as the default setting instead.
// - master clock 00 gives 512/256/128 sps, cutoff 01 gives 40.96 Hz (28.35 at 128), 10 gives 102.4 Hz.
// - master clock 01 gives 500/250/125 sps, cutoff 00 bypasses, 01 is 40.00 (27.68 at 125), 10 is 100.0, 11 is 150.0 at 500.
// - master clocks 10 and 11 support only rate code 10 (200 or 199.8 sps) with bypass or a 40.00 or 39.96 Hz cutoff.
// - beat detector configuration lives in two read/write registers, gains first, timing second.
// - window field bits 23:20 select 6 to 28 units of 8 ms in steps of two.
// - window field resets to 0011 (96 ms) and codes 1100 and above are reserved.
// - gain field bits 19:16 select a gain of two to the field for codes up to 1110.
// - gain code 1111 is auto scale, the reset default, starting at a gain of 64.
// - beat detection is active only when its enable bit 15 and the ecg channel enable are both set.
// - peak weight bits 13:12 select 2/4/8/16 and the peak average is (peak+(w-1)*avg)/w.
// - threshold scale bits 11:8 give (field+1)/16 of the peak average, default 0011.
// - hold-off bits 21:16 of the second register take 0 to 63, default 32, in detector ticks.
package ercf_pkg;
	localparam logic [6:0] ADDR_CFG_A = 7'h1d;
	localparam logic [6:0] ADDR_CFG_B = 7'h1e;
	localparam logic [23:0] CFG_A_RESET = 24'h3f_2300;
	localparam logic [23:0] CFG_B_RESET = 24'h20_2400;
	localparam logic [23:0] CFG_A_MASK = 24'hff_bf00;
	localparam logic [23:0] CFG_B_MASK = 24'h3f_3700;
	localparam int WND_LSB = 20;
	localparam int GAIN_LSB = 16;
	localparam int EN_POS = 15;
	localparam int PEAK_AVERAGE_WEIGHT_LSB = 12;
	localparam int PEAK_THRESHOLD_SCALE_LSB = 8;
	localparam int MIN_HOLDOFF_INTERVAL_LSB = 16;
	localparam logic [3:0] WND_FIRST_RESERVED = 4'hc;
	localparam logic [3:0] GAIN_AUTO = 4'hf;
	localparam logic [14:0] GAIN_AUTO_START = 15'h0040;
	localparam logic [4:0] WND_BASE_UNITS = 5'h06;
	localparam logic [1:0] RATE_DEFAULT = 2'h2;
	localparam logic [1:0] LPF_BYPASS = 2'h0;
	localparam logic [1:0] LPF_DEFAULT = 2'h1;
	// sample rates in tenths of sps, cutoffs in hundredths of hz
	localparam logic [15:0] SPS_512 = 16'h1400;
	localparam logic [15:0] SPS_256 = 16'h0a00;
	localparam logic [15:0] SPS_128 = 16'h0500;
	localparam logic [15:0] SPS_500 = 16'h1388;
	localparam logic [15:0] SPS_250 = 16'h09c4;
	localparam logic [15:0] SPS_125 = 16'h04e2;
	localparam logic [15:0] SPS_200 = 16'h07d0;
	localparam logic [15:0] SPS_199P8 = 16'h07ce;
	localparam logic [15:0] HZ_BYPASS = 16'h0000;
	localparam logic [15:0] HZ_40P96 = 16'h1000;
	localparam logic [15:0] HZ_102P4 = 16'h2800;
	localparam logic [15:0] HZ_153P6 = 16'h3c00;
	localparam logic [15:0] HZ_28P35 = 16'h0b13;
	localparam logic [15:0] HZ_40P00 = 16'h0fa0;
	localparam logic [15:0] HZ_100P0 = 16'h2710;
	localparam logic [15:0] HZ_150P0 = 16'h3a98;
	localparam logic [15:0] HZ_27P68 = 16'h0ad0;
	localparam logic [15:0] HZ_39P96 = 16'h0f9c;
endpackage

// File: rtl/ercf_top.sv
// rate/cutoff decode and beat detector configuration registers
// assumes the serial host port hands over decoded word accesses on sys_clk
`timescale 1ns/1ns
module ercf_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// register port
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [23:0] reg_wdata,
	output logic [23:0] reg_rdata,
	output logic reg_rvalid,
	// settings held elsewhere
	input wire logic [1:0] master_clock_select,
	input wire logic [1:0] rate_code,
	input wire logic [1:0] lowpass_cutoff_code,
	input wire logic ecg_channel_enable,
	// effective rate and filter
	output logic [1:0] eff_rate_code,
	output logic [1:0] eff_cutoff_code,
	output logic [15:0] sample_rate_dsps,
	output logic [15:0] cutoff_chz,
	// beat detector settings
	output logic beat_detect_active,
	output logic [4:0] window_units,
	output logic [14:0] detector_gain,
	output logic gain_auto_scale,
	output logic [5:0] min_holdoff_ticks,
	// peak tracking
	input wire logic peak_valid,
	input wire logic [15:0] peak_value,
	output logic [15:0] peak_average,
	output logic [15:0] peak_threshold
);

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic rate_ok(input logic [1:0] mc, input logic [1:0] rc);
		rate_ok = mc[1] ? (rc == 2'h2) : (rc != 2'h3);
	endfunction

	function automatic logic cut_ok(input logic [1:0] mc, input logic [1:0] rc, input logic [1:0] lc);
		case (lc)
			2'h0: cut_ok = 1'b1;
			2'h1: cut_ok = 1'b1;
			2'h2: cut_ok = !mc[1] && (rc != 2'h2);
			2'h3: cut_ok = !mc[1] && (rc == 2'h0);
			default: cut_ok = 1'b0;
		endcase
	endfunction

	logic [1:0] rate_sel;
	logic [1:0] cut_sel;
	logic [15:0] sps_sel;
	logic [15:0] hz_sel;

	always_comb begin
		rate_sel = rate_ok(master_clock_select, rate_code) ? rate_code : ercf_pkg::RATE_DEFAULT;
		cut_sel = cut_ok(master_clock_select, rate_sel, lowpass_cutoff_code) ?
			lowpass_cutoff_code : ercf_pkg::LPF_DEFAULT;
		sps_sel = ercf_pkg::SPS_128;
		hz_sel = ercf_pkg::HZ_BYPASS;
		case (master_clock_select)
			2'h0: begin
				case (rate_sel)
					2'h0: sps_sel = ercf_pkg::SPS_512;
					2'h1: sps_sel = ercf_pkg::SPS_256;
					default: sps_sel = ercf_pkg::SPS_128;
				endcase
				if (cut_sel == 2'h1) begin
					hz_sel = (rate_sel == 2'h2) ? ercf_pkg::HZ_28P35 : ercf_pkg::HZ_40P96;
				end else if (cut_sel == 2'h2) begin
					hz_sel = ercf_pkg::HZ_102P4;
				end else if (cut_sel == 2'h3) begin
					hz_sel = ercf_pkg::HZ_153P6;
				end
			end
			2'h1: begin
				case (rate_sel)
					2'h0: sps_sel = ercf_pkg::SPS_500;
					2'h1: sps_sel = ercf_pkg::SPS_250;
					default: sps_sel = ercf_pkg::SPS_125;
				endcase
				if (cut_sel == 2'h1) begin
					hz_sel = (rate_sel == 2'h2) ? ercf_pkg::HZ_27P68 : ercf_pkg::HZ_40P00;
				end else if (cut_sel == 2'h2) begin
					hz_sel = ercf_pkg::HZ_100P0;
				end else if (cut_sel == 2'h3) begin
					hz_sel = ercf_pkg::HZ_150P0;
				end
			end
			2'h2: begin
				sps_sel = ercf_pkg::SPS_200;
				hz_sel = (cut_sel == ercf_pkg::LPF_BYPASS) ? ercf_pkg::HZ_BYPASS : ercf_pkg::HZ_40P00;
			end
			default: begin
				sps_sel = ercf_pkg::SPS_199P8;
				hz_sel = (cut_sel == ercf_pkg::LPF_BYPASS) ? ercf_pkg::HZ_BYPASS : ercf_pkg::HZ_39P96;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			eff_rate_code <= ercf_pkg::RATE_DEFAULT;
			eff_cutoff_code <= ercf_pkg::LPF_DEFAULT;
			sample_rate_dsps <= ercf_pkg::SPS_128;
			cutoff_chz <= ercf_pkg::HZ_28P35;
		end else begin
			eff_rate_code <= rate_sel;
			eff_cutoff_code <= cut_sel;
			sample_rate_dsps <= sps_sel;
			cutoff_chz <= hz_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	logic [23:0] cfg_a_reg;
	logic [23:0] cfg_b_reg;
	logic [23:0] cfg_a_next;

	localparam int WND_HI = ercf_pkg::WND_LSB + 3;
	localparam int GAIN_HI = ercf_pkg::GAIN_LSB + 3;
	localparam int PEAK_THRESHOLD_SCALE_HI = ercf_pkg::PEAK_THRESHOLD_SCALE_LSB + 3;
	localparam int PEAK_AVERAGE_WEIGHT_HI = ercf_pkg::PEAK_AVERAGE_WEIGHT_LSB + 1;
	localparam int MIN_HOLDOFF_INTERVAL_HI = ercf_pkg::MIN_HOLDOFF_INTERVAL_LSB + 5;

	always_comb begin
		cfg_a_next = reg_wdata & ercf_pkg::CFG_A_MASK;
		if (reg_wdata[WND_HI:ercf_pkg::WND_LSB] >= ercf_pkg::WND_FIRST_RESERVED) begin
			cfg_a_next[WND_HI:ercf_pkg::WND_LSB] = cfg_a_reg[WND_HI:ercf_pkg::WND_LSB];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_a_reg <= ercf_pkg::CFG_A_RESET;
			cfg_b_reg <= ercf_pkg::CFG_B_RESET;
		end else if (reg_wr) begin
			if (reg_addr == ercf_pkg::ADDR_CFG_A) begin
				cfg_a_reg <= cfg_a_next;
			end
			if (reg_addr == ercf_pkg::ADDR_CFG_B) begin
				cfg_b_reg <= reg_wdata & ercf_pkg::CFG_B_MASK;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 24'h00_0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (!reg_rd) begin
				reg_rdata <= 24'h00_0000;
			end else if (reg_addr == ercf_pkg::ADDR_CFG_A) begin
				reg_rdata <= cfg_a_reg;
			end else if (reg_addr == ercf_pkg::ADDR_CFG_B) begin
				reg_rdata <= cfg_b_reg;
			end else begin
				reg_rdata <= 24'h00_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// field decode

	logic [3:0] gain_code;
	logic [3:0] gain_code_prev;
	assign gain_code = cfg_a_reg[GAIN_HI:ercf_pkg::GAIN_LSB];

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			window_units <= ercf_pkg::WND_BASE_UNITS + {ercf_pkg::CFG_A_RESET[WND_HI:ercf_pkg::WND_LSB], 1'b0};
			detector_gain <= ercf_pkg::GAIN_AUTO_START;
			gain_auto_scale <= 1'b1;
			gain_code_prev <= ercf_pkg::GAIN_AUTO;
			beat_detect_active <= 1'b0;
			min_holdoff_ticks <= ercf_pkg::CFG_B_RESET[MIN_HOLDOFF_INTERVAL_HI:ercf_pkg::MIN_HOLDOFF_INTERVAL_LSB];
		end else begin
			window_units <= ercf_pkg::WND_BASE_UNITS
				+ {cfg_a_reg[WND_HI:ercf_pkg::WND_LSB], 1'b0};
			gain_code_prev <= gain_code;
			gain_auto_scale <= (gain_code == ercf_pkg::GAIN_AUTO);
			if (gain_code != ercf_pkg::GAIN_AUTO) begin
				detector_gain <= 15'h0001 << gain_code;
			end else if (gain_code_prev != ercf_pkg::GAIN_AUTO) begin
				detector_gain <= ercf_pkg::GAIN_AUTO_START;
			end
			beat_detect_active <= cfg_a_reg[ercf_pkg::EN_POS] && ecg_channel_enable;
			min_holdoff_ticks <= cfg_b_reg[MIN_HOLDOFF_INTERVAL_HI:ercf_pkg::MIN_HOLDOFF_INTERVAL_LSB];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// peak average and threshold

	logic [1:0] peak_average_weight_code;
	logic [4:0] weight_less_one;
	logic [20:0] avg_sum;
	logic [19:0] thr_prod;
	assign peak_average_weight_code = cfg_a_reg[PEAK_AVERAGE_WEIGHT_HI:ercf_pkg::PEAK_AVERAGE_WEIGHT_LSB];
	assign weight_less_one = (5'h02 << peak_average_weight_code) - 5'h01;
	assign avg_sum = {5'h00, peak_value} + 21'(weight_less_one * peak_average);
	assign thr_prod = peak_average * ({1'b0, cfg_a_reg[PEAK_THRESHOLD_SCALE_HI:ercf_pkg::PEAK_THRESHOLD_SCALE_LSB]} + 5'h01);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			peak_average <= 16'h0000;
		end else if (peak_valid) begin
			// shift widened so weight 16 does not wrap to a shift of zero
			peak_average <= 16'(avg_sum >> ({1'b0, peak_average_weight_code} + 3'h1));
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			peak_threshold <= 16'h0000;
		end else begin
			peak_threshold <= thr_prod[19:4];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	a_bypass_kept: assert property (@(posedge sys_clk) disable iff (!nrst)
		(lowpass_cutoff_code == 2'h0) |=> (eff_cutoff_code == 2'h0 && cutoff_chz == 16'h0000))
		else $error("bypass cutoff not kept");
	a_cutoff_default: assert property (@(posedge sys_clk) disable iff (!nrst)
		(master_clock_select == 2'h0 && rate_code == 2'h2 && lowpass_cutoff_code == 2'h3)
		|=> (eff_cutoff_code == 2'h1 && cutoff_chz == 16'h0b13))
		else $error("unsupported cutoff not substituted");
	a_cutoff_102: assert property (@(posedge sys_clk) disable iff (!nrst)
		(master_clock_select == 2'h0 && rate_code == 2'h1 && lowpass_cutoff_code == 2'h2)
		|=> (cutoff_chz == 16'h2800 && sample_rate_dsps == 16'h0a00))
		else $error("256 sps 102.4 hz wrong");
	a_cutoff_150: assert property (@(posedge sys_clk) disable iff (!nrst)
		(master_clock_select == 2'h1 && rate_code == 2'h0 && lowpass_cutoff_code == 2'h3)
		|=> (cutoff_chz == 16'h3a98 && sample_rate_dsps == 16'h1388))
		else $error("500 sps 150 hz wrong");
	a_rate_forced: assert property (@(posedge sys_clk) disable iff (!nrst)
		(master_clock_select[1] && rate_code != 2'h2) |=> (eff_rate_code == 2'h2))
		else $error("rate not forced to default");
	a_window_map: assert property (@(posedge sys_clk) disable iff (!nrst)
		##1 (window_units == 5'(6 + 2 * $past(cfg_a_reg[23:20]))))
		else $error("window width mapping wrong");
	a_window_reserved: assert property (@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && reg_addr == 7'h1d && reg_wdata[23:20] >= 4'hc) |=> $stable(cfg_a_reg[23:20]))
		else $error("reserved window code stored");
	a_gain_power: assert property (@(posedge sys_clk) disable iff (!nrst)
		(cfg_a_reg[19:16] != 4'hf) |=> (detector_gain == (15'h0001 << $past(cfg_a_reg[19:16]))))
		else $error("gain not two to the code");
	a_auto_start: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(cfg_a_reg[19:16] == 4'hf) |=> (detector_gain == 15'h0040 && gain_auto_scale))
		else $error("auto scale did not start at 64");
	a_enable_both: assert property (@(posedge sys_clk) disable iff (!nrst)
		##1 (beat_detect_active == ($past(cfg_a_reg[15]) && $past(ecg_channel_enable))))
		else $error("beat detect enable gating wrong");
	a_holdoff_copy: assert property (@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && reg_addr == 7'h1e) |=> ##1 (min_holdoff_ticks == $past(reg_wdata[21:16], 2)))
		else $error("hold-off not taken from write");
	a_unused_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
		((cfg_a_reg & ~24'hff_bf00) == 24'h00_0000 && (cfg_b_reg & ~24'h3f_3700) == 24'h00_0000))
		else $error("unused register bits not zero");
	a_read_valid: assert property (@(posedge sys_clk) disable iff (!nrst)
		reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_read_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
		!reg_rd |=> (!reg_rvalid && reg_rdata == 24'h00_0000))
		else $error("read data not idle");
	a_read_first: assert property (@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && reg_addr == 7'h1d) |=> (reg_rdata == $past(cfg_a_reg)))
		else $error("first register read wrong");
	a_read_second: assert property (@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && reg_addr == 7'h1e) |=> (reg_rdata == $past(cfg_b_reg)))
		else $error("second register read wrong");
	a_write_first: assert property (@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && reg_addr == 7'h1d && reg_wdata[23:20] < 4'hc) |=> (cfg_a_reg == ($past(reg_wdata) & 24'hff_bf00)))
		else $error("first register write not masked");
	a_write_second: assert property (@(posedge sys_clk) disable iff (!nrst)
		(reg_wr && reg_addr == 7'h1e) |=> (cfg_b_reg == ($past(reg_wdata) & 24'h3f_3700)))
		else $error("second register write not masked");
	a_peak_held: assert property (@(posedge sys_clk) disable iff (!nrst)
		!peak_valid |=> $stable(peak_average))
		else $error("peak average moved without a peak");
	a_weight_two: assert property (@(posedge sys_clk) disable iff (!nrst)
		(peak_valid && cfg_a_reg[13:12] == 2'h0) |=>
		(peak_average == 16'((17'($past(peak_value)) + 17'($past(peak_average))) >> 1)))
		else $error("weight two average wrong");
	a_weight_sixteen: assert property (@(posedge sys_clk) disable iff (!nrst)
		(peak_valid && cfg_a_reg[13:12] == 2'h3) |=>
		(peak_average == 16'((21'($past(peak_value)) + 21'h00_000f * 21'($past(peak_average))) >> 4)))
		else $error("weight sixteen average wrong");
	a_threshold_frac: assert property (@(posedge sys_clk) disable iff (!nrst)
		##1 (peak_threshold == 16'((20'($past(peak_average)) * ({1'b0, $past(cfg_a_reg[11:8])} + 5'h01)) >> 4)))
		else $error("threshold fraction wrong");

endmodule

// File: dv/ercf_top_tb_top.sv
// self-checking bench for the rate/cutoff decode and beat detector configuration
// assumes ercf_top and ercf_pkg compiled first; bench drives every port directly
`timescale 1ns/1ns
module ercf_top_tb_top;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [23:0] reg_wdata = 24'h00_0000;
	logic [23:0] reg_rdata;
	logic reg_rvalid;
	logic [1:0] master_clock_select = 2'h0;
	logic [1:0] rate_code = 2'h0;
	logic [1:0] lowpass_cutoff_code = 2'h0;
	logic ecg_channel_enable = 1'b0;
	logic [1:0] eff_rate_code, eff_cutoff_code;
	logic [15:0] sample_rate_dsps, cutoff_chz, peak_average, peak_threshold;
	logic beat_detect_active, gain_auto_scale;
	logic [4:0] window_units;
	logic [14:0] detector_gain;
	logic [5:0] min_holdoff_ticks;
	logic peak_valid = 1'b0;
	logic [15:0] peak_value = 16'h0000;
	int failures = 0;
	int checks = 0;
	ercf_top uut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.master_clock_select(master_clock_select), .rate_code(rate_code),
		.lowpass_cutoff_code(lowpass_cutoff_code), .ecg_channel_enable(ecg_channel_enable),
		.eff_rate_code(eff_rate_code), .eff_cutoff_code(eff_cutoff_code), .sample_rate_dsps(sample_rate_dsps),
		.cutoff_chz(cutoff_chz), .beat_detect_active(beat_detect_active), .window_units(window_units),
		.detector_gain(detector_gain), .gain_auto_scale(gain_auto_scale), .min_holdoff_ticks(min_holdoff_ticks),
		.peak_valid(peak_valid), .peak_value(peak_value), .peak_average(peak_average),
		.peak_threshold(peak_threshold));
	always #25 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [6:0] a, input logic [23:0] e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rvalid", 36'h1, reg_rvalid);
		chk("reg_rdata", e, reg_rdata);
	endtask
	task automatic peak(input logic [15:0] p, input logic [15:0] ea, input logic [15:0] et);
		@(posedge sys_clk);
		peak_value <= p;
		peak_valid <= 1'b1;
		@(posedge sys_clk);
		peak_valid <= 1'b0;
		#1;
		chk("peak_average", ea, peak_average);
		@(posedge sys_clk);
		#1;
		chk("peak_threshold", et, peak_threshold);
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// expected {rate, cutoff, sps, cutoff hz} from the supported table
	function automatic logic [35:0] dec(input logic [1:0] m, input logic [1:0] r, input logic [1:0] c);
		logic [1:0] er;
		logic [1:0] ec;
		logic [15:0] s;
		logic [15:0] f;
		er = (r == 2'h3 || (m[1] && r != 2'h2)) ? ercf_pkg::RATE_DEFAULT : r;
		ec = c;
		if (c != 2'h0 && (m[1] || er == 2'h2 || (er == 2'h1 && c == 2'h3))) ec = ercf_pkg::LPF_DEFAULT;
		case (m)
			2'h0: s = er == 2'h0 ? ercf_pkg::SPS_512 : er == 2'h1 ? ercf_pkg::SPS_256 : ercf_pkg::SPS_128;
			2'h1: s = er == 2'h0 ? ercf_pkg::SPS_500 : er == 2'h1 ? ercf_pkg::SPS_250 : ercf_pkg::SPS_125;
			2'h2: s = ercf_pkg::SPS_200;
			default: s = ercf_pkg::SPS_199P8;
		endcase
		if (ec == 2'h0) f = ercf_pkg::HZ_BYPASS;
		else if (m == 2'h2) f = ercf_pkg::HZ_40P00;
		else if (m == 2'h3) f = ercf_pkg::HZ_39P96;
		else if (er == 2'h2) f = m[0] ? ercf_pkg::HZ_27P68 : ercf_pkg::HZ_28P35;
		else if (ec == 2'h1) f = m[0] ? ercf_pkg::HZ_40P00 : ercf_pkg::HZ_40P96;
		else if (ec == 2'h2) f = m[0] ? ercf_pkg::HZ_100P0 : ercf_pkg::HZ_102P4;
		else f = m[0] ? ercf_pkg::HZ_150P0 : ercf_pkg::HZ_153P6;
		return {er, ec, s, f};
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(ercf_pkg::ADDR_CFG_A, 24'h3f_2300);
		rd(ercf_pkg::ADDR_CFG_B, 24'h20_2400);
		chk("window_units", 36'hc, window_units);
		chk("detector_gain", 36'h40, detector_gain);
		chk("gain_auto_scale", 36'h1, gain_auto_scale);
		chk("min_holdoff_ticks", 36'h20, min_holdoff_ticks);
		rd(7'h1f, 24'h00_0000);
		wr(7'h1c, 24'hff_ffff);
		rd(ercf_pkg::ADDR_CFG_A, 24'h3f_2300);
		wr(ercf_pkg::ADDR_CFG_A, 24'hbe_ffff);
		rd(ercf_pkg::ADDR_CFG_A, 24'hbe_bf00);
		wr(ercf_pkg::ADDR_CFG_B, 24'hff_ffff);
		rd(ercf_pkg::ADDR_CFG_B, 24'h3f_3700);
		chk("min_holdoff_ticks", 36'h3f, min_holdoff_ticks);
		for (int i = 0; i < 15; i++) begin
			wr(ercf_pkg::ADDR_CFG_A, {4'h3, i[3:0], 16'h0000});
			chk("detector_gain", 36'h1 << i, detector_gain);
			chk("gain_auto_scale", 36'h0, gain_auto_scale);
		end
		wr(ercf_pkg::ADDR_CFG_A, 24'h3f_0000);
		chk("detector_gain", 36'h40, detector_gain);
		chk("gain_auto_scale", 36'h1, gain_auto_scale);
		for (int i = 0; i < 12; i++) begin
			wr(ercf_pkg::ADDR_CFG_A, {i[3:0], 4'hf, 16'h0000});
			chk("window_units", 36'h6 + 2 * i, window_units);
		end
		wr(ercf_pkg::ADDR_CFG_A, 24'hcf_0000);
		chk("window_units", 36'h1c, window_units);
		rd(ercf_pkg::ADDR_CFG_A, 24'hbf_0000);
		wr(ercf_pkg::ADDR_CFG_A, 24'h3f_8f00);
		chk("beat_detect_active", 36'h0, beat_detect_active);
		@(posedge sys_clk);
		ecg_channel_enable <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("beat_detect_active", 36'h1, beat_detect_active);
		peak(16'h03e8, 16'h01f4, 16'h01f4);
		wr(ercf_pkg::ADDR_CFG_A, 24'h3f_3300);
		chk("peak_threshold", 36'h7d, peak_threshold);
		chk("beat_detect_active", 36'h0, beat_detect_active);
		peak(16'h0a00, 16'h0274, 16'h009d);
		for (int m = 0; m < 4; m++) begin
			for (int r = 0; r < 4; r++) begin
				for (int c = 0; c < 4; c++) begin
					@(posedge sys_clk);
					master_clock_select <= m[1:0];
					rate_code <= r[1:0];
					lowpass_cutoff_code <= c[1:0];
					repeat (2) @(posedge sys_clk);
					#1;
					chk("decode", dec(m[1:0], r[1:0], c[1:0]),
						{eff_rate_code, eff_cutoff_code, sample_rate_dsps, cutoff_chz});
				end
			end
		end
		wrap_up();
	end
endmodule
